// >>> pkg/omc_pkg.sv
// Constants, encodings and the state type for the operating mode controller.
// Assumes one clock domain and a byte-wide software register port.
`default_nettype none

package omc_pkg;

  // Register indices on the software port.
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MODE   = 4'h2;

  // Control register fields.
  localparam int CTRL_STOP_EN   = 0;
  localparam int CTRL_PD_SEL    = 1;
  localparam int CTRL_LV_EN     = 2;
  localparam int CTRL_LV_STOP   = 3;
  localparam int CTRL_DBG_EN    = 4;
  localparam int CTRL_RTI_STOP  = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields.
  localparam int STAT_PD_FLAG = 0;
  localparam int STAT_PD_ACK  = 1;

  // Reset vector location, high byte address then low byte address.
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;

  // Serial link bit time in debug clock cycles.
  localparam int BIT_CYCLES = 16;

  // Debug command classes.
  localparam logic [2:0] CMD_MEM      = 3'h0;
  localparam logic [2:0] CMD_MEM_STAT = 3'h1;
  localparam logic [2:0] CMD_DREG     = 3'h2;
  localparam logic [2:0] CMD_BKGND    = 3'h3;
  localparam logic [2:0] CMD_CPUREG   = 3'h4;
  localparam logic [2:0] CMD_TRACE    = 3'h5;
  localparam logic [2:0] CMD_GO       = 3'h6;

  typedef enum logic [2:0] {
    ST_BOOT  = 3'h0,
    ST_RUN   = 3'h1,
    ST_BKGND = 3'h2,
    ST_WAIT  = 3'h3,
    ST_STOP3 = 3'h4,
    ST_STOP2 = 3'h5
  } omc_state_e;

endpackage

`default_nettype wire

// >>> rtl/omc_mode_ctrl.sv
// Operating mode controller: run, background, wait and the two stop modes.
// Assumes CPU events and debug commands arrive as one-cycle strobes synchronous to i_clock.
// Functional notes
// - Mode pin high at reset: run, reset vector
// - Pin low, command, halt, breakpoint: background
// - Non-intrusive commands accepted in run and background
// - Background: CPU suspended; register, trace, resume allowed
// - Wait: CPU clock off, interrupt mask cleared
// - Interrupt ends wait, stacking starts
// - Wait accepts only background and status commands
// - Background command in wait enters background
// - Stop with enable set picks stop mode
// - Stop with enable clear forces illegal opcode reset
// - Partial stop needs select, enable, no detector
// - Detector enabled in stop forces retention stop
// - Partial stop: only RAM powered, wakeup optional
// - Pins latched until acknowledge written with one
// - Partial stop exits: reset, low irq, wakeup
// - Partial stop wake restarts as power-on
// - Wake flag set until acknowledge written
// - Opened latches: port or enabled peripheral drives
// - Retention stop keeps all state and pins
// - Retention stop exits by reset or interrupts
// - Debug enable keeps debug clock, forces retention
// - Stop with debug: background command also wakes
// - Bit time is sixteen debug clocks
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module omc_mode_ctrl #(
  parameter int NPINS = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_mode_select,
  input  wire logic             i_reset_pin_b,
  input  wire logic             i_irq_pin_b,
  input  wire logic             i_exec_halt,
  input  wire logic             i_exec_wait,
  input  wire logic             i_exec_stop,
  input  wire logic             i_breakpoint,
  input  wire logic             i_irq_req,
  input  wire logic             i_rti_irq,
  input  wire logic             i_lvd_irq,
  input  wire logic             i_adc_irq,
  input  wire logic             i_kbi_irq,
  input  wire logic             i_cmd_valid,
  input  wire logic [2:0]       i_cmd,
  input  wire logic [NPINS-1:0] i_port_out,
  input  wire logic [NPINS-1:0] i_periph_en,
  input  wire logic [NPINS-1:0] i_periph_out,
  input  wire logic [3:0]       i_addr,
  input  wire logic [7:0]       i_wr_data,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic [7:0]            o_rd_data,
  output logic [2:0]            o_mode,
  output logic                  o_cpu_clk_en,
  output logic                  o_sys_clk_en,
  output logic                  o_dbg_clk_en,
  output logic                  o_reg_full,
  output logic                  o_core_power,
  output logic                  o_rti_run,
  output logic                  o_vector_fetch,
  output logic [15:0]           o_vector_addr,
  output logic                  o_illegal_reset,
  output logic                  o_por_restart,
  output logic                  o_clear_imask,
  output logic                  o_irq_stack,
  output logic                  o_trace_step,
  output logic                  o_cmd_ack,
  output logic                  o_cmd_err,
  output logic                  o_cmd_refused,
  output logic                  o_pin_hold,
  output logic [NPINS-1:0]      o_pin_out,
  output logic                  o_bit_tick
);

  omc_pkg::omc_state_e state_r;
  omc_pkg::omc_state_e state_nxt;
  logic [7:0]          ctrl_r;
  logic                pd_flag_r;
  logic                dbg_keep_r;
  logic                stop_kind_stop3;
  logic                cmd_ok;
  logic                cmd_status_err;
  logic                ack_write;
  logic                stop2_wake;
  logic                stop3_irq;
  logic                restart;
  logic [3:0]          bit_cnt_r;

  assign ack_write  = i_wr && (i_addr == omc_pkg::ADDR_STATUS) && i_wr_data[omc_pkg::STAT_PD_ACK];
  // The irq pin is taken as active low here whatever it was set up as before.
  assign stop2_wake = !i_reset_pin_b || !i_irq_pin_b
                      || (i_rti_irq && ctrl_r[omc_pkg::CTRL_RTI_STOP]);
  assign stop3_irq  = i_rti_irq || i_lvd_irq || i_adc_irq || !i_irq_pin_b || i_kbi_irq;
  // Retention stop wins whenever the detector or the debug logic must stay alive.
  assign stop_kind_stop3 = !ctrl_r[omc_pkg::CTRL_PD_SEL]
                           || (ctrl_r[omc_pkg::CTRL_LV_EN] && ctrl_r[omc_pkg::CTRL_LV_STOP])
                           || ctrl_r[omc_pkg::CTRL_DBG_EN];
  always_comb
  begin
    cmd_ok         = 1'b0;
    cmd_status_err = 1'b0;
    case (state_r)
      omc_pkg::ST_RUN:   cmd_ok = (i_cmd <= omc_pkg::CMD_BKGND);
      omc_pkg::ST_BKGND: cmd_ok = (i_cmd <= omc_pkg::CMD_GO);
      omc_pkg::ST_WAIT:
      begin
        cmd_ok         = (i_cmd == omc_pkg::CMD_BKGND) || (i_cmd == omc_pkg::CMD_MEM_STAT);
        cmd_status_err = (i_cmd == omc_pkg::CMD_MEM_STAT);
      end
      omc_pkg::ST_STOP3:
      begin
        cmd_ok         = dbg_keep_r && ((i_cmd == omc_pkg::CMD_BKGND)
                                        || (i_cmd == omc_pkg::CMD_MEM_STAT));
        cmd_status_err = dbg_keep_r && (i_cmd == omc_pkg::CMD_MEM_STAT);
      end
      default:           cmd_ok = 1'b0;
    endcase
  end
  always_comb
  begin
    state_nxt = state_r;
    restart   = 1'b0;
    case (state_r)
      omc_pkg::ST_BOOT:
        state_nxt = i_mode_select ? omc_pkg::ST_RUN : omc_pkg::ST_BKGND;
      omc_pkg::ST_RUN:
      begin
        if ((i_cmd_valid && i_cmd == omc_pkg::CMD_BKGND) || i_exec_halt || i_breakpoint)
          state_nxt = omc_pkg::ST_BKGND;
        else if (i_exec_wait)
          state_nxt = omc_pkg::ST_WAIT;
        else if (i_exec_stop && !ctrl_r[omc_pkg::CTRL_STOP_EN])
        begin
          state_nxt = omc_pkg::ST_BOOT;
          restart   = 1'b1;
        end
        else if (i_exec_stop)
          state_nxt = stop_kind_stop3 ? omc_pkg::ST_STOP3 : omc_pkg::ST_STOP2;
      end
      omc_pkg::ST_BKGND:
        if (i_cmd_valid && i_cmd == omc_pkg::CMD_GO)
          state_nxt = omc_pkg::ST_RUN;
      omc_pkg::ST_WAIT:
        if (i_cmd_valid && i_cmd == omc_pkg::CMD_BKGND)
          state_nxt = omc_pkg::ST_BKGND;
        else if (i_irq_req)
          state_nxt = omc_pkg::ST_RUN;
      omc_pkg::ST_STOP3:
        if (!i_reset_pin_b)
        begin
          state_nxt = omc_pkg::ST_BOOT;
          restart   = 1'b1;
        end
        else if (dbg_keep_r && i_cmd_valid && i_cmd == omc_pkg::CMD_BKGND)
          state_nxt = omc_pkg::ST_BKGND;
        else if (stop3_irq)
          state_nxt = omc_pkg::ST_RUN;
      omc_pkg::ST_STOP2:
        if (stop2_wake)
        begin
          state_nxt = omc_pkg::ST_BOOT;
          restart   = 1'b1;
        end
      default:
        state_nxt = omc_pkg::ST_BOOT;
    endcase
  end
  // Leaving reset goes through the boot state so that the mode pin is sampled on a clock edge.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_r <= omc_pkg::ST_BOOT;
    else
      state_r <= state_nxt;
  end
  // Debug clocking is decided at stop entry, not followed live during the stop.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      dbg_keep_r <= 1'b0;
    else if (state_r == omc_pkg::ST_RUN && state_nxt == omc_pkg::ST_STOP3)
      dbg_keep_r <= ctrl_r[omc_pkg::CTRL_DBG_EN];
    else if (state_nxt != omc_pkg::ST_STOP3)
      dbg_keep_r <= 1'b0;
  end
  // Control bits return to defaults on any restart, like the rest of the peripherals.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ctrl_r <= omc_pkg::CTRL_RESET;
    else if (restart)
      ctrl_r <= omc_pkg::CTRL_RESET;
    else if (i_wr && i_addr == omc_pkg::ADDR_CTRL)
      ctrl_r <= i_wr_data;
  end
  // A wake in the same cycle as the acknowledge keeps the flag set.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pd_flag_r <= 1'b0;
    else if (state_r == omc_pkg::ST_STOP2 && stop2_wake)
      pd_flag_r <= 1'b1;
    else if (ack_write)
      pd_flag_r <= 1'b0;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rd_data <= 8'h00;
    else if (i_rd)
      case (i_addr)
        omc_pkg::ADDR_CTRL:   o_rd_data <= ctrl_r;
        omc_pkg::ADDR_STATUS: o_rd_data <= {7'h00, pd_flag_r};
        omc_pkg::ADDR_MODE:   o_rd_data <= {5'h00, state_r};
        default:              o_rd_data <= 8'h00;
      endcase
    else
      o_rd_data <= 8'h00;
  end
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_mode       <= omc_pkg::ST_BOOT;
      o_cpu_clk_en <= 1'b0;
      o_sys_clk_en <= 1'b0;
      o_dbg_clk_en <= 1'b1;
      o_reg_full   <= 1'b1;
      o_core_power <= 1'b1;
      o_rti_run    <= 1'b0;
    end
    else
    begin
      o_mode       <= state_nxt;
      o_cpu_clk_en <= (state_nxt == omc_pkg::ST_RUN);
      o_sys_clk_en <= (state_nxt != omc_pkg::ST_STOP2) && (state_nxt != omc_pkg::ST_STOP3);
      o_dbg_clk_en <= (state_nxt != omc_pkg::ST_STOP2)
                      && ((state_nxt != omc_pkg::ST_STOP3)
                          || (state_r == omc_pkg::ST_RUN ? ctrl_r[omc_pkg::CTRL_DBG_EN]
                                                         : dbg_keep_r));
      o_reg_full   <= (state_nxt != omc_pkg::ST_STOP2)
                      && ((state_nxt != omc_pkg::ST_STOP3)
                          || (state_r == omc_pkg::ST_RUN ? ctrl_r[omc_pkg::CTRL_DBG_EN]
                                                         : dbg_keep_r));
      o_core_power <= (state_nxt != omc_pkg::ST_STOP2);
      o_rti_run    <= ctrl_r[omc_pkg::CTRL_RTI_STOP]
                      || (state_nxt != omc_pkg::ST_STOP2 && state_nxt != omc_pkg::ST_STOP3);
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_vector_fetch  <= 1'b0;
      o_vector_addr   <= 16'h0000;
      o_illegal_reset <= 1'b0;
      o_por_restart   <= 1'b0;
      o_clear_imask   <= 1'b0;
      o_irq_stack     <= 1'b0;
      o_trace_step    <= 1'b0;
    end
    else
    begin
      o_vector_fetch  <= (state_r == omc_pkg::ST_BOOT) && i_mode_select;
      o_vector_addr   <= omc_pkg::RESET_VECTOR;
      o_illegal_reset <= (state_r == omc_pkg::ST_RUN) && i_exec_stop && !i_exec_wait
                         && !ctrl_r[omc_pkg::CTRL_STOP_EN] && (state_nxt == omc_pkg::ST_BOOT);
      o_por_restart   <= (state_r == omc_pkg::ST_STOP2) && stop2_wake;
      o_clear_imask   <= (state_r == omc_pkg::ST_RUN) && (state_nxt == omc_pkg::ST_WAIT);
      o_irq_stack     <= ((state_r == omc_pkg::ST_WAIT) || (state_r == omc_pkg::ST_STOP3))
                         && (state_nxt == omc_pkg::ST_RUN);
      o_trace_step    <= (state_r == omc_pkg::ST_BKGND) && i_cmd_valid
                         && (i_cmd == omc_pkg::CMD_TRACE);
    end
  end
  // Command answers; commands in stop2 or in stop3 without debug clock are answered with o_cmd_refused.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_cmd_ack     <= 1'b0;
      o_cmd_err     <= 1'b0;
      o_cmd_refused <= 1'b0;
    end
    else
    begin
      o_cmd_ack     <= i_cmd_valid && cmd_ok && !cmd_status_err;
      o_cmd_err     <= i_cmd_valid && cmd_ok && cmd_status_err;
      o_cmd_refused <= i_cmd_valid && !cmd_ok;
    end
  end
  // Pins latch on any stop entry; stop3 opens them on exit, stop2 only on acknowledge.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_pin_hold <= 1'b0;
    else if (state_r == omc_pkg::ST_RUN
             && (state_nxt == omc_pkg::ST_STOP2 || state_nxt == omc_pkg::ST_STOP3))
      o_pin_hold <= 1'b1;
    else if (state_r == omc_pkg::ST_STOP3 && state_nxt != omc_pkg::ST_STOP3)
      o_pin_hold <= 1'b0;
    else if (ack_write && state_r != omc_pkg::ST_STOP2 && state_r != omc_pkg::ST_STOP3)
      o_pin_hold <= 1'b0;
  end
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      always_ff @(posedge i_clock or negedge i_rst_b)
      begin
        if (!i_rst_b)
          o_pin_out[g] <= 1'b0;
        else if (!o_pin_hold)
          o_pin_out[g] <= i_periph_en[g] ? i_periph_out[g] : i_port_out[g];
      end
    end
  endgenerate
  // Free-running bit timer; the link samples one bit per tick.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      bit_cnt_r  <= 4'h0;
      o_bit_tick <= 1'b0;
    end
    else
    begin
      bit_cnt_r  <= bit_cnt_r + 4'h1;
      o_bit_tick <= (bit_cnt_r == 4'(omc_pkg::BIT_CYCLES - 1));
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  property p_boot_run;
    (state_r == omc_pkg::ST_BOOT) && i_mode_select |=> (state_r == omc_pkg::ST_RUN) && o_vector_fetch;
  endproperty
  a_boot_run: assert property (p_boot_run) else $error("Boot with pin high did not run.");
  property p_boot_bkgnd;
    (state_r == omc_pkg::ST_BOOT) && !i_mode_select |=> (state_r == omc_pkg::ST_BKGND);
  endproperty
  a_boot_bkgnd: assert property (p_boot_bkgnd) else $error("Boot with pin low missed background.");
  property p_run_cmd;
    (state_r == omc_pkg::ST_RUN) && i_cmd_valid && (i_cmd == omc_pkg::CMD_CPUREG) |=> o_cmd_refused;
  endproperty
  a_run_cmd: assert property (p_run_cmd) else $error("Register command taken in run.");
  property p_wait_entry;
    (state_r == omc_pkg::ST_RUN) && i_exec_wait && !i_exec_halt && !i_breakpoint && !i_cmd_valid
    |=> o_clear_imask && !o_cpu_clk_en && o_sys_clk_en;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("Wait entry wrong.");
  property p_wait_irq;
    (state_r == omc_pkg::ST_WAIT) && i_irq_req && !i_cmd_valid |=> o_irq_stack ##1 o_cpu_clk_en;
  endproperty
  a_wait_irq: assert property (p_wait_irq) else $error("Interrupt did not end wait.");
  property p_wait_stat;
    (state_r == omc_pkg::ST_WAIT) && i_cmd_valid && (i_cmd == omc_pkg::CMD_MEM_STAT) |=> o_cmd_err;
  endproperty
  a_wait_stat: assert property (p_wait_stat) else $error("Status command in wait gave no error.");
  property p_wait_bkgnd;
    (state_r == omc_pkg::ST_WAIT) && i_cmd_valid && (i_cmd == omc_pkg::CMD_BKGND)
    |=> (state_r == omc_pkg::ST_BKGND);
  endproperty
  a_wait_bkgnd: assert property (p_wait_bkgnd) else $error("Background did not wake wait.");
  property p_stop_illegal;
    (state_r == omc_pkg::ST_RUN) && i_exec_stop && !i_exec_wait && !i_exec_halt && !i_breakpoint
    && !i_cmd_valid && !ctrl_r[omc_pkg::CTRL_STOP_EN] |=> o_illegal_reset && (state_r == omc_pkg::ST_BOOT);
  endproperty
  a_stop_illegal: assert property (p_stop_illegal) else $error("Illegal stop not reset.");
  property p_dbg_stop3;
    (state_r == omc_pkg::ST_RUN) && ctrl_r[omc_pkg::CTRL_DBG_EN] |=> (state_r != omc_pkg::ST_STOP2);
  endproperty
  a_dbg_stop3: assert property (p_dbg_stop3) else $error("Partial stop with debug enabled.");
  property p_flag_hold;
    pd_flag_r && !ack_write |=> pd_flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Wake flag dropped early.");
  property p_stop2_hold;
    (state_r == omc_pkg::ST_STOP2) |-> o_pin_hold && !o_core_power;
  endproperty
  a_stop2_hold: assert property (p_stop2_hold) else $error("Partial stop lost pin hold.");
  property p_bit_tick;
    o_bit_tick |=> !o_bit_tick [*8] ##1 !o_bit_tick [*7] ##1 o_bit_tick;
  endproperty
  a_bit_tick: assert property (p_bit_tick) else $error("Bit time is not sixteen cycles.");

  c_stop2_wake: cover property ((state_r == omc_pkg::ST_STOP2) ##1 o_por_restart);
  c_stop3_irq:  cover property ((state_r == omc_pkg::ST_STOP3) ##1 o_irq_stack);
  c_go:         cover property ((state_r == omc_pkg::ST_BKGND) ##1 (state_r == omc_pkg::ST_RUN));
  c_wait_bkgnd: cover property ((state_r == omc_pkg::ST_WAIT) ##1 (state_r == omc_pkg::ST_BKGND));

endmodule // omc_mode_ctrl

`default_nettype wire

// >>> tb/omc_dbg_host.sv
// Debug host model: issues one command class per request over the command strobe.
// Assumes the block takes a command on the edge where the strobe is high.
`timescale 1ns/1ps
`default_nettype none

module omc_dbg_host (
  input  wire logic       i_clock,
  output logic            o_cmd_valid,
  output logic [2:0]      o_cmd
);
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd       = 3'h7;
  end

  // A released command bus shows the inverse so a stale value never passes for a command.
  task automatic send(input logic [2:0] c, input int gap);
    repeat (gap) @(posedge i_clock);
    o_cmd_valid <= 1'b1;
    o_cmd       <= c;
    @(posedge i_clock);
    o_cmd_valid <= 1'b0;
    o_cmd       <= ~c;
  endtask
endmodule // omc_dbg_host

`default_nettype wire

// >>> tb/tb_omc_mode_ctrl.sv
// Bench for the operating mode controller: mode entry, exit, commands and pin latches.
// Assumes one clock and the register port answering one cycle after a read strobe.
`timescale 1ns/1ps
`default_nettype none

module tb_omc_mode_ctrl;
  logic        i_clock = 1'b0, i_rst_b = 1'b0, i_mode_select = 1'b1;
  logic        i_reset_pin_b = 1'b1, i_irq_pin_b = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0]  ev = 4'h0, i_addr = 4'h0, i_port_out = 4'hA, i_periph_en = 4'h1;
  logic [3:0]  i_periph_out = 4'h0;
  logic [4:0]  irq = 5'h00;
  logic [7:0]  i_wr_data = 8'h00, o_rd_data;
  logic [2:0]  o_mode, i_cmd;
  logic [15:0] o_vector_addr;
  logic [3:0]  o_pin_out;
  logic        i_cmd_valid, o_cpu_clk_en, o_dbg_clk_en, o_core_power, o_vector_fetch;
  logic        o_illegal_reset, o_por_restart, o_clear_imask, o_irq_stack, o_trace_step;
  logic        o_cmd_ack, o_cmd_err, o_cmd_refused, o_pin_hold;
  logic        o_sys_clk_en, o_reg_full, o_rti_run, o_bit_tick;
  int          fails = 0, comparisons = 0, cycles = 0, gap = 0;

  initial
  begin
    forever #5 i_clock = ~i_clock;
  end

  omc_dbg_host omc_dbg_host_i (.i_clock, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));

  omc_mode_ctrl #(.NPINS(4)) omc_mode_ctrl_i (
    .i_clock, .i_rst_b, .i_mode_select, .i_reset_pin_b, .i_irq_pin_b,
    .i_exec_halt(ev[0]), .i_exec_wait(ev[1]), .i_exec_stop(ev[2]), .i_breakpoint(ev[3]),
    .i_irq_req(irq[0]), .i_rti_irq(irq[1]), .i_lvd_irq(irq[2]), .i_adc_irq(irq[3]),
    .i_kbi_irq(irq[4]), .i_cmd_valid, .i_cmd, .i_port_out, .i_periph_en, .i_periph_out,
    .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .o_mode, .o_cpu_clk_en,
    .o_sys_clk_en, .o_dbg_clk_en, .o_reg_full, .o_core_power, .o_rti_run,
    .o_vector_fetch, .o_vector_addr, .o_illegal_reset, .o_por_restart, .o_clear_imask,
    .o_irq_stack, .o_trace_step, .o_cmd_ack, .o_cmd_err, .o_cmd_refused, .o_pin_hold,
    .o_pin_out, .o_bit_tick);

  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run;
    $display("counts comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // The hang limit is more than twenty times the length of the whole sequence.
  always @(posedge i_clock)
  begin
    cycles++;
    // The first tick after a reset only proves the timer started, so it is not timed.
    if (o_bit_tick && gap > 0)
      chk("bit time", 20'h10, 20'(gap));
    gap = !i_rst_b ? 0 : (o_bit_tick ? 1 : ((gap > 0) ? gap + 1 : 0));
    if (cycles == 3000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic rst(input logic ms);
    @(posedge i_clock) i_rst_b <= 1'b0;
    i_mode_select <= ms;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock) #1;
  endtask

  task automatic pulse(input int k);
    @(posedge i_clock) ev[k] <= 1'b1;
    @(posedge i_clock) ev <= 4'h0;
    #1;
  endtask

  task automatic irqw(input int k);
    @(posedge i_clock) irq[k] <= 1'b1;
    @(posedge i_clock) irq <= 5'h00;
    #1 chk("irq exit", 20'h3, {o_mode, o_irq_stack});
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock) i_wr <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_clock) i_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clock) i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock) i_rd <= 1'b0;
    #1 chk("read data", e, o_rd_data);
  endtask

  task automatic cmdc(input logic [2:0] c, input logic [2:0] r, input logic [2:0] md);
    omc_dbg_host_i.send(c, 1);
    #1 chk("command", {r, md}, {o_cmd_ack, o_cmd_err, o_cmd_refused, o_mode});
  endtask

  initial
  begin
    rst(1'b1);
    chk("boot run", 20'h3FFFE, {o_mode, o_vector_fetch, o_vector_addr});
    // Background goes last so that every run-mode refusal is seen in run.
    for (int c = 4; c < 12; c++)
      cmdc(c[2:0], (c > 7) ? 3'h4 : 3'h1, (c == 11) ? 3'h2 : 3'h1);
    cmdc(omc_pkg::CMD_GO, 3'h4, 3'h1);
    pulse(0);
    chk("halt", 20'h2, o_mode);
    for (int c = 0; c < 6; c++)
      cmdc(c[2:0], 3'h4, 3'h2);
    cmdc(omc_pkg::CMD_GO, 3'h4, 3'h1);
    pulse(3);
    chk("breakpoint", 20'h2, o_mode);
    cmdc(omc_pkg::CMD_TRACE, 3'h4, 3'h2);
    chk("trace", 20'h1, o_trace_step);
    cmdc(omc_pkg::CMD_GO, 3'h4, 3'h1);
    $display("test run and background done");
    pulse(1);
    chk("wait entry", 20'h1B, {o_mode, o_cpu_clk_en, o_clear_imask, o_sys_clk_en});
    cmdc(omc_pkg::CMD_MEM, 3'h1, 3'h3);
    cmdc(omc_pkg::CMD_MEM_STAT, 3'h2, 3'h3);
    cmdc(omc_pkg::CMD_BKGND, 3'h4, 3'h2);
    cmdc(omc_pkg::CMD_GO, 3'h4, 3'h1);
    pulse(1);
    irqw(0);
    $display("test wait done");
    wreg(omc_pkg::ADDR_CTRL, 8'h00);
    pulse(2);
    chk("illegal stop", 20'h1, {o_mode, o_illegal_reset});
    wreg(omc_pkg::ADDR_CTRL, 8'h03);
    pulse(2);
    chk("stop2 entry", 20'h16, {o_mode, o_pin_hold, o_core_power});
    chk("stop2 clocks", 20'h0, {o_sys_clk_en, o_reg_full, o_rti_run});
    @(posedge i_clock) i_port_out <= 4'h5;
    cmdc(omc_pkg::CMD_BKGND, 3'h1, 3'h5);
    @(posedge i_clock) i_irq_pin_b <= 1'b0;
    @(posedge i_clock) i_irq_pin_b <= 1'b1;
    #1 chk("stop2 wake", 20'h1A, {o_mode, o_por_restart, o_pin_out});
    @(posedge i_clock) #1;
    chk("restart", 20'h3, {o_mode, o_vector_fetch});
    rchk(omc_pkg::ADDR_STATUS, 8'h01);
    rchk(omc_pkg::ADDR_CTRL, 8'h00);
    wreg(omc_pkg::ADDR_STATUS, 8'h02);
    rchk(omc_pkg::ADDR_STATUS, 8'h00);
    chk("pins open", 20'h04, {o_pin_hold, o_pin_out});
    $display("test stop2 done");
    wreg(omc_pkg::ADDR_CTRL, 8'h13);
    pulse(2);
    chk("stop3 debug", 20'h26, {o_mode, o_dbg_clk_en, o_reg_full, o_rti_run});
    cmdc(omc_pkg::CMD_MEM_STAT, 3'h2, 3'h4);
    cmdc(omc_pkg::CMD_MEM, 3'h1, 3'h4);
    cmdc(omc_pkg::CMD_BKGND, 3'h4, 3'h2);
    cmdc(omc_pkg::CMD_GO, 3'h4, 3'h1);
    wreg(omc_pkg::ADDR_CTRL, 8'h2F);
    for (int k = 1; k < 5; k++)
    begin
      pulse(2);
      chk("stop3", 20'h10, {o_mode, o_dbg_clk_en, o_cpu_clk_en});
      chk("stop3 rti", 20'h1, {o_reg_full, o_rti_run});
      irqw(k);
    end
    pulse(2);
    @(posedge i_clock) i_reset_pin_b <= 1'b0;
    @(posedge i_clock) i_reset_pin_b <= 1'b1;
    #1 chk("stop3 reset pin", 20'h0, o_mode);
    $display("test stop3 done");
    rst(1'b0);
    chk("pin low boot", 20'h2, o_mode);
    rchk(omc_pkg::ADDR_MODE, 8'h02);
    rchk(4'h7, 8'h00);
    $display("test register port done");
    complete_run();
  end
endmodule // tb_omc_mode_ctrl

`default_nettype wire
